// File: cwpd_map.vh
// Address map, field positions, reset values and codes of the configuration word decoder.
`ifndef CWPD_MAP_VH
`define CWPD_MAP_VH
// ----------------------------------------
// APB byte offsets
// ----------------------------------------
`define CWPD_OFF_CTRL 12'h000
`define CWPD_OFF_STATUS 12'h004
`define CWPD_OFF_CFG1 12'h008
`define CWPD_OFF_CFG2 12'h00C
`define CWPD_OFF_IDENT 12'h010
`define CWPD_OFF_EXT_ADDR 12'h014
`define CWPD_OFF_EXT_WDATA 12'h018
`define CWPD_OFF_EXT_CMD 12'h01C
`define CWPD_OFF_EXT_RDATA 12'h020
`define CWPD_OFF_CPU_ADDR 12'h024
`define CWPD_OFF_CPU_CMD 12'h028
`define CWPD_OFF_CPU_RESULT 12'h02C
// ----------------------------------------
// Configuration space word addresses
// ----------------------------------------
`define CWPD_USERID_BASE 16'h8000
`define CWPD_USERID_LAST 16'h8003
`define CWPD_IDENT_ADDR 16'h8006
`define CWPD_CFG1_ADDR 16'h8007
`define CWPD_CFG2_ADDR 16'h8008
`define CWPD_PROG_LAST 16'h7FFF
`define CWPD_EE_BASE 16'hF000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CWPD_CFG1_DATA_GUARD 8
`define CWPD_CFG1_PROG_GUARD 7
`define CWPD_CFG2_LVP 13
`define CWPD_CFG2_DEBUG 12
`define CWPD_CFG2_BROWNOUT 10
`define CWPD_CFG2_STACK 9
`define CWPD_CFG2_PLL 8
`define CWPD_CFG2_FIXED_ONES 14'h08EC
`define CWPD_CFG2_PROG_MASK 14'h3713
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CWPD_CFG_ERASED 14'h3FFF
`define CWPD_PART_CODE 9'h0_0A5
`define CWPD_STEP_CODE 5'h0_3
`define CWPD_WRT_NONE 2'h3
`define CWPD_WRT_LIM_HALF 16'h01FF
`define CWPD_WRT_LIM_QUART 16'h03FF
`define CWPD_WRT_LIM_ALL 16'h07FF
`define CWPD_OSC_ECH 3'h7
`define CWPD_OSC_ECM 3'h6
`define CWPD_OSC_ECL 3'h5
`define CWPD_OSC_INT 3'h4
`define CWPD_OSC_RC 3'h3
`define CWPD_OSC_HS 3'h2
`define CWPD_OSC_XT 3'h1
`define CWPD_OSC_LP 3'h0
`endif

// File: cwpd_config_decode.v
// Configuration word decoder with code protection and self-write guard over APB.
//
// Design decision made here: the APB interface to the registers.
`include "cwpd_map.vh"
`default_nettype none
module cwpd_config_decode (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Programming entry pins
	input wire lvp_entry_pin,
	input wire hv_entry_pin,
	// Decoded selections
	output reg ext_clock_high,
	output reg ext_clock_medium,
	output reg ext_clock_low,
	output reg internal_osc,
	output reg resistor_capacitor_osc,
	output reg high_gain_crystal,
	output reg medium_gain_crystal,
	output reg low_gain_watch_crystal,
	output reg clock_input_pin_is_io,
	output reg crystal_pins_active,
	output reg low_volt_prog_enable,
	output reg debug_pins_dedicated,
	output reg brownout_level_select,
	output reg stack_fault_reset_enable,
	output reg freq_multiplier_enable,
	output reg prog_session_active,
	// Non-volatile word bus to the memory array
	output reg nvm_req,
	output reg nvm_we,
	output reg [15:0] nvm_addr,
	output reg [13:0] nvm_wdata,
	input wire [13:0] nvm_rdata
);

// ----------------------------------------
// Declarations
// ----------------------------------------
reg lvp_s1_reg, lvp_s2_reg, hv_s1_reg, hv_s2_reg;
reg [13:0] cfg1_reg, cfg2_reg;
reg [1:0] load_reg;
reg in_lvp_reg, in_hv_reg;
reg [13:0] user_id_reg [0:3];
reg [15:0] ext_addr_reg, cpu_addr_reg;
reg [13:0] ext_wdata_reg, ext_rdata_reg;
reg [2:0] ext_stat_reg, cpu_stat_reg;
reg [1:0] st_reg;
reg [1:0] who_reg;
reg [31:0] rd_next;
wire wr_en, rd_en;
wire [2:0] osc_field;
wire [1:0] wrt_field;
wire ext_prog, ext_ee, ext_uid, cpu_prog, cpu_ee, cpu_uid;
wire prog_guard_on, ee_guard_on, cpu_wr_blocked;
integer i;
localparam ST_IDLE = 2'd0;
localparam ST_LOAD = 2'd1;
localparam ST_RUN = 2'd2;
localparam ST_ACC = 2'd3;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		lvp_s1_reg <= 1'b0;
		lvp_s2_reg <= 1'b0;
		hv_s1_reg <= 1'b0;
		hv_s2_reg <= 1'b0;
	end else begin
		lvp_s1_reg <= lvp_entry_pin;
		lvp_s2_reg <= lvp_s1_reg;
		hv_s1_reg <= hv_entry_pin;
		hv_s2_reg <= hv_s1_reg;
	end
end

// ----------------------------------------
// Decode helpers
// ----------------------------------------
assign wr_en = psel && penable && pwrite;
assign rd_en = psel && !penable && !pwrite;
assign osc_field = cfg1_reg[2:0];
assign wrt_field = cfg2_reg[1:0];
assign prog_guard_on = !cfg1_reg[`CWPD_CFG1_PROG_GUARD];
assign ee_guard_on = !cfg1_reg[`CWPD_CFG1_DATA_GUARD];
assign ext_prog = ext_addr_reg <= `CWPD_PROG_LAST;
assign ext_ee = ext_addr_reg >= `CWPD_EE_BASE;
assign ext_uid = ext_addr_reg >= `CWPD_USERID_BASE && ext_addr_reg <= `CWPD_USERID_LAST;
assign cpu_prog = cpu_addr_reg <= `CWPD_PROG_LAST;
assign cpu_ee = cpu_addr_reg >= `CWPD_EE_BASE;
assign cpu_uid = cpu_addr_reg >= `CWPD_USERID_BASE && cpu_addr_reg <= `CWPD_USERID_LAST;
// Self-write guard: 11 none, 10 to 1FFh, 01 to 3FFh, 00 to 7FFh.
assign cpu_wr_blocked = cpu_prog && (
	(wrt_field == 2'b10 && cpu_addr_reg <= `CWPD_WRT_LIM_HALF) ||
	(wrt_field == 2'b01 && cpu_addr_reg <= `CWPD_WRT_LIM_QUART) ||
	(wrt_field == 2'b00 && cpu_addr_reg <= `CWPD_WRT_LIM_ALL));

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
	rd_next = 32'h0000_0000;
	case (paddr)
	`CWPD_OFF_CTRL: rd_next = {30'h0000_0000, in_hv_reg, in_lvp_reg};
	`CWPD_OFF_STATUS: rd_next = {26'h0000_000, cpu_stat_reg, ext_stat_reg};
	`CWPD_OFF_CFG1: rd_next = {18'h0_0000, cfg1_reg};
	`CWPD_OFF_CFG2: rd_next = {18'h0_0000, cfg2_reg | `CWPD_CFG2_FIXED_ONES};
	`CWPD_OFF_IDENT: rd_next = {18'h0_0000, `CWPD_PART_CODE, `CWPD_STEP_CODE};
	`CWPD_OFF_EXT_ADDR: rd_next = {16'h0000, ext_addr_reg};
	`CWPD_OFF_EXT_WDATA: rd_next = {18'h0_0000, ext_wdata_reg};
	`CWPD_OFF_EXT_RDATA: rd_next = {18'h0_0000, ext_rdata_reg};
	`CWPD_OFF_CPU_ADDR: rd_next = {16'h0000, cpu_addr_reg};
	default: rd_next = 32'h0000_0000;
	endcase
end

// ----------------------------------------
// Main sequencer
// ----------------------------------------
// Status codes: 1 done, 2 refused by guard; code 3 is never set.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		st_reg <= ST_IDLE;
		load_reg <= 2'd0;
		cfg1_reg <= `CWPD_CFG_ERASED;
		cfg2_reg <= `CWPD_CFG_ERASED;
		in_lvp_reg <= 1'b0;
		in_hv_reg <= 1'b0;
		ext_addr_reg <= 16'h0000;
		cpu_addr_reg <= 16'h0000;
		ext_wdata_reg <= 14'h0000;
		ext_rdata_reg <= 14'h0000;
		ext_stat_reg <= 3'd0;
		cpu_stat_reg <= 3'd0;
		who_reg <= 2'd0;
		nvm_req <= 1'b0;
		nvm_we <= 1'b0;
		nvm_addr <= 16'h0000;
		nvm_wdata <= 14'h0000;
		prdata <= 32'h0000_0000;
		pready <= 1'b0;
		pslverr <= 1'b0;
		prog_session_active <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			user_id_reg[i] <= 14'h0000;
		end
	end else begin
		pready <= psel && !penable;
		pslverr <= 1'b0;
		if (rd_en) begin
			prdata <= rd_next;
		end
		if (psel && !penable && paddr > `CWPD_OFF_CPU_RESULT) begin
			pslverr <= 1'b1;
		end
		nvm_req <= 1'b0;
		case (st_reg)
		ST_IDLE: begin
			// Both words are fetched once after reset and then frozen.
			nvm_req <= 1'b1;
			nvm_we <= 1'b0;
			nvm_addr <= `CWPD_CFG1_ADDR;
			load_reg <= 2'd0;
			st_reg <= ST_LOAD;
		end
		ST_LOAD: begin
			if (load_reg == 2'd0) begin
				cfg1_reg <= nvm_rdata;
				nvm_req <= 1'b1;
				nvm_addr <= `CWPD_CFG2_ADDR;
				load_reg <= 2'd1;
			end else begin
				cfg2_reg <= nvm_rdata;
				in_lvp_reg <= lvp_s2_reg && nvm_rdata[`CWPD_CFG2_LVP];
				in_hv_reg <= hv_s2_reg;
				prog_session_active <= hv_s2_reg || (lvp_s2_reg && nvm_rdata[`CWPD_CFG2_LVP]);
				st_reg <= ST_RUN;
			end
		end
		ST_ACC: begin
			if (who_reg == 2'd1) begin
				ext_rdata_reg <= nvm_rdata;
				ext_stat_reg <= 3'd1;
			end else begin
				cpu_stat_reg <= 3'd1;
			end
			st_reg <= ST_RUN;
		end
		default: begin
			if (wr_en && paddr == `CWPD_OFF_EXT_ADDR) begin
				ext_addr_reg <= pwdata[15:0];
			end
			if (wr_en && paddr == `CWPD_OFF_EXT_WDATA) begin
				ext_wdata_reg <= pwdata[13:0];
			end
			if (wr_en && paddr == `CWPD_OFF_CPU_ADDR) begin
				cpu_addr_reg <= pwdata[15:0];
			end
			if (wr_en && paddr == `CWPD_OFF_EXT_CMD) begin
				// External party: bit0 read, bit1 write.
				if (!prog_session_active) begin
					ext_stat_reg <= 3'd2;
				end else if (ext_addr_reg == `CWPD_IDENT_ADDR && pwdata[1]) begin
					ext_stat_reg <= 3'd2;
				end else if (ext_prog && prog_guard_on) begin
					ext_rdata_reg <= 14'h0000;
					ext_stat_reg <= 3'd2;
				end else if (ext_ee && ee_guard_on) begin
					ext_rdata_reg <= 14'h0000;
					ext_stat_reg <= 3'd2;
				end else if (pwdata[1] && ext_addr_reg == `CWPD_CFG2_ADDR && in_lvp_reg
					&& !ext_wdata_reg[`CWPD_CFG2_LVP]) begin
					ext_stat_reg <= 3'd2;
				end else if (ext_uid && pwdata[1]) begin
					user_id_reg[ext_addr_reg[1:0]] <= ext_wdata_reg;
					ext_stat_reg <= 3'd1;
				end else if (ext_uid) begin
					ext_rdata_reg <= user_id_reg[ext_addr_reg[1:0]];
					ext_stat_reg <= 3'd1;
				end else if (ext_addr_reg == `CWPD_IDENT_ADDR) begin
					ext_rdata_reg <= {`CWPD_PART_CODE, `CWPD_STEP_CODE};
					ext_stat_reg <= 3'd1;
				end else if (pwdata[0] || pwdata[1]) begin
					nvm_req <= 1'b1;
					nvm_we <= pwdata[1];
					nvm_addr <= ext_addr_reg;
					nvm_wdata <= (ext_addr_reg == `CWPD_CFG2_ADDR) ?
						(ext_wdata_reg & `CWPD_CFG2_PROG_MASK) : ext_wdata_reg;
					who_reg <= 2'd1;
					st_reg <= ST_ACC;
				end
			end else if (wr_en && paddr == `CWPD_OFF_CPU_CMD) begin
				// Internal CPU: reads never guarded, writes refused by the self-guard and at the identity word.
				if (pwdata[1] && (cpu_wr_blocked || cpu_addr_reg == `CWPD_IDENT_ADDR)) begin
					cpu_stat_reg <= 3'd2;
				end else if (cpu_uid && pwdata[1]) begin
					user_id_reg[cpu_addr_reg[1:0]] <= pwdata[29:16];
					cpu_stat_reg <= 3'd1;
				end else if (cpu_uid) begin
					ext_rdata_reg <= user_id_reg[cpu_addr_reg[1:0]];
					cpu_stat_reg <= 3'd1;
				end else if (pwdata[0] || pwdata[1]) begin
					nvm_req <= 1'b1;
					nvm_we <= pwdata[1];
					nvm_addr <= cpu_addr_reg;
					nvm_wdata <= pwdata[29:16];
					who_reg <= 2'd2;
					st_reg <= ST_ACC;
				end
			end
		end
		endcase
	end
end

// ----------------------------------------
// Selection outputs from latched words
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ext_clock_high <= 1'b0;
		ext_clock_medium <= 1'b0;
		ext_clock_low <= 1'b0;
		internal_osc <= 1'b0;
		resistor_capacitor_osc <= 1'b0;
		high_gain_crystal <= 1'b0;
		medium_gain_crystal <= 1'b0;
		low_gain_watch_crystal <= 1'b0;
		clock_input_pin_is_io <= 1'b0;
		crystal_pins_active <= 1'b0;
		low_volt_prog_enable <= 1'b0;
		debug_pins_dedicated <= 1'b0;
		brownout_level_select <= 1'b0;
		stack_fault_reset_enable <= 1'b0;
		freq_multiplier_enable <= 1'b0;
	end else begin
		ext_clock_high <= osc_field == `CWPD_OSC_ECH;
		ext_clock_medium <= osc_field == `CWPD_OSC_ECM;
		ext_clock_low <= osc_field == `CWPD_OSC_ECL;
		internal_osc <= osc_field == `CWPD_OSC_INT;
		clock_input_pin_is_io <= osc_field == `CWPD_OSC_INT;
		resistor_capacitor_osc <= osc_field == `CWPD_OSC_RC;
		high_gain_crystal <= osc_field == `CWPD_OSC_HS;
		medium_gain_crystal <= osc_field == `CWPD_OSC_XT;
		low_gain_watch_crystal <= osc_field == `CWPD_OSC_LP;
		crystal_pins_active <= osc_field <= `CWPD_OSC_HS;
		low_volt_prog_enable <= cfg2_reg[`CWPD_CFG2_LVP];
		debug_pins_dedicated <= !cfg2_reg[`CWPD_CFG2_DEBUG];
		brownout_level_select <= cfg2_reg[`CWPD_CFG2_BROWNOUT];
		stack_fault_reset_enable <= cfg2_reg[`CWPD_CFG2_STACK];
		freq_multiplier_enable <= cfg2_reg[`CWPD_CFG2_PLL];
	end
end

endmodule
`default_nettype wire

// File: cwpd_nvm_model.sv
// Behavioural non-volatile word array behind the decoder.
`default_nettype none
module cwpd_nvm_model (
	// Word bus
	input wire logic pclk,
	input wire logic nvm_req,
	input wire logic nvm_we,
	input wire logic [15:0] nvm_addr,
	input wire logic [13:0] nvm_wdata,
	output var logic [13:0] nvm_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Array
	// ----------------------------------------
	// Only the low address nibble is decoded, so words alias; the bench keeps its words apart.
	logic [13:0] mem [0:15];
	logic [13:0] idle_q;
	initial begin
		idle_q = 14'h0000;
		foreach (mem[i]) mem[i] = 14'h3FFF;
	end
	// The word stands while the request is high, since the decoder takes it at the next edge.
	// Outside an answer the data toggles, so a stale word is never taken for a fresh one.
	always @(posedge pclk) begin
		if (nvm_req && nvm_we) mem[nvm_addr[3:0]] <= nvm_wdata;
		idle_q <= ~idle_q;
	end
	assign nvm_rdata = nvm_req ? mem[nvm_addr[3:0]] : idle_q;
endmodule
`default_nettype wire

// File: cwpd_asserts.sv
// Port checker of the configuration word decoder.
`include "cwpd_map.vh"
`default_nettype none
module cwpd_asserts (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	// Decoded selections
	input wire ext_clock_high,
	input wire ext_clock_medium,
	input wire ext_clock_low,
	input wire internal_osc,
	input wire resistor_capacitor_osc,
	input wire high_gain_crystal,
	input wire medium_gain_crystal,
	input wire low_gain_watch_crystal,
	input wire clock_input_pin_is_io,
	input wire crystal_pins_active,
	input wire low_volt_prog_enable,
	input wire debug_pins_dedicated,
	input wire brownout_level_select,
	input wire stack_fault_reset_enable,
	input wire freq_multiplier_enable,
	// Word bus
	input wire nvm_req,
	input wire [15:0] nvm_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [2:0] age_reg;
	wire [7:0] osc_v = {ext_clock_high, ext_clock_medium, ext_clock_low, internal_osc,
		resistor_capacitor_osc, high_gain_crystal, medium_gain_crystal, low_gain_watch_crystal};
	wire rd_set = psel && !penable && !pwrite;
	wire ok = age_reg >= 3'h5;
	always @(posedge pclk or negedge presetn)
		if (!presetn) age_reg <= 3'h0;
		else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
	sequence s_ld1;
		nvm_req && nvm_addr == `CWPD_CFG1_ADDR;
	endsequence
	sequence s_ld2;
		nvm_req && nvm_addr == `CWPD_CFG2_ADDR;
	endsequence
	AST_OSC_ONEHOT: assert property (ok |-> $onehot(osc_v) && clock_input_pin_is_io == internal_osc)
		else $error("oscillator selection not one-hot");
	AST_XTAL_PINS: assert property (ok |-> crystal_pins_active == (osc_v[2:0] != 3'h0))
		else $error("crystal pins disagree with mode");
	AST_HOLD: assert property (ok |=> $stable(osc_v) && $stable(low_volt_prog_enable))
		else $error("selection changed without reset");
	AST_LOAD_ORDER: assert property ($rose(presetn) |-> ##[1:2] s_ld1 ##1 s_ld2)
		else $error("configuration words not fetched in order");
	AST_IDENT: assert property (rd_set && paddr == `CWPD_OFF_IDENT
		|=> prdata == {18'h0, `CWPD_PART_CODE, `CWPD_STEP_CODE}) else $error("identity word wrong");
	AST_CFG2_ONES: assert property (rd_set && paddr == `CWPD_OFF_CFG2
		|=> (prdata[13:0] & `CWPD_CFG2_FIXED_ONES) == `CWPD_CFG2_FIXED_ONES) else $error("ones lost");
	AST_CFG2_DECODE: assert property (ok && rd_set && paddr == `CWPD_OFF_CFG2
		|=> prdata[13] == low_volt_prog_enable && prdata[12] != debug_pins_dedicated
		&& prdata[10] == brownout_level_select && prdata[9] == stack_fault_reset_enable
		&& prdata[8] == freq_multiplier_enable) else $error("word two decode wrong");
	AST_CFG1_OSC: assert property (ok && rd_set && paddr == `CWPD_OFF_CFG1
		|=> osc_v == 8'h01 << prdata[2:0]) else $error("oscillator decode wrong");
endmodule
bind cwpd_config_decode cwpd_asserts chk (.*);
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the configuration word decoder.
`include "cwpd_map.vh"
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic lvp_entry_pin = 1'b0, hv_entry_pin = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, nvm_req, nvm_we, ext_clock_high, ext_clock_medium, ext_clock_low;
	logic internal_osc, resistor_capacitor_osc, high_gain_crystal, medium_gain_crystal;
	logic low_gain_watch_crystal, clock_input_pin_is_io, crystal_pins_active;
	logic low_volt_prog_enable, debug_pins_dedicated, brownout_level_select;
	logic stack_fault_reset_enable, freq_multiplier_enable, prog_session_active;
	logic [15:0] nvm_addr;
	logic [13:0] nvm_wdata, nvm_rdata;
	logic [7:0] osc_v;
	logic [4:0] cfg2_v;
	int err_count = 0, checked = 0;
	assign osc_v = {ext_clock_high, ext_clock_medium, ext_clock_low, internal_osc,
		resistor_capacitor_osc, high_gain_crystal, medium_gain_crystal, low_gain_watch_crystal};
	assign cfg2_v = {low_volt_prog_enable, debug_pins_dedicated, brownout_level_select,
		stack_fault_reset_enable, freq_multiplier_enable};
	cwpd_config_decode dut (.*);
	cwpd_nvm_model nvm (.*);
	always #2.5 pclk = ~pclk;
	// ----------------------------------------
	// Bus and command tasks
	// ----------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		if (n >= 50) begin
			err_count++;
			results();
		end
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rd, e)
	endtask
	task automatic st(input int sh, input logic [2:0] e);
		apb(1'b0, `CWPD_OFF_STATUS, 32'h0000_0000);
		`CHK(rd[sh+:3], e)
	endtask
	task automatic boot(input logic [13:0] c1, input logic [13:0] c2, input logic hv, input logic lv);
		nvm.mem[7] = c1;
		nvm.mem[8] = c2;
		{presetn, hv_entry_pin, lvp_entry_pin} <= {1'b0, hv, lv};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask
	task automatic cmd(input logic c, input logic [15:0] a, input logic [13:0] d, input logic [1:0] k);
		apb(1'b1, c ? `CWPD_OFF_CPU_ADDR : `CWPD_OFF_EXT_ADDR, {16'h0000, a});
		if (c)
			apb(1'b1, `CWPD_OFF_CPU_CMD, {2'h0, d, 14'h0000, k});
		else begin
			apb(1'b1, `CWPD_OFF_EXT_WDATA, {18'h0_0000, d});
			apb(1'b1, `CWPD_OFF_EXT_CMD, {30'h0000_0000, k});
		end
		repeat (3) @(posedge pclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_decode;
		for (int k = 0; k < 8; k++) begin
			logic [2:0] o;
			logic [13:0] c2;
			o = k[2:0];
			c2 = {o[0], ~o[1], 1'b1, o[2], ~o[0], o[1], 8'hFF};
			boot({11'h7FF, o}, c2, 1'b0, 1'b0);
			`CHK(osc_v, 8'h01 << o)
			`CHK(clock_input_pin_is_io, o == 3'h4)
			`CHK(crystal_pins_active, o < 3'h3)
			`CHK(cfg2_v, {o[0], o[1], o[2], ~o[0], o[1]})
			rchk(`CWPD_OFF_CFG2, {18'h0, c2 | `CWPD_CFG2_FIXED_ONES});
			rchk(`CWPD_OFF_CFG1, {18'h0, 11'h7FF, o});
		end
	endtask
	task automatic t_ident;
		boot(14'h3FFC, 14'h3FFF, 1'b1, 1'b0);
		cmd(1'b0, `CWPD_IDENT_ADDR, 14'h0000, 2'h2);
		st(0, 3'h2);
		rchk(`CWPD_OFF_IDENT, {18'h0, `CWPD_PART_CODE, `CWPD_STEP_CODE});
		cmd(1'b0, `CWPD_CFG1_ADDR, 14'h3FFF, 2'h2);
		`CHK(osc_v, 8'h10)
		cmd(1'b0, 16'h8001, 14'h2A5C, 2'h2);
		cmd(1'b0, 16'h8001, 14'h0000, 2'h1);
		rchk(`CWPD_OFF_EXT_RDATA, 32'h0000_2A5C);
	endtask
	task automatic t_guard;
		nvm.mem[5] = 14'h1234;
		nvm.mem[0] = 14'h0ABC;
		boot(14'h3F7F, 14'h3FFF, 1'b1, 1'b0);
		cmd(1'b0, 16'h0005, 14'h0000, 2'h1);
		st(0, 3'h2);
		rchk(`CWPD_OFF_EXT_RDATA, 32'h0000_0000);
		cmd(1'b0, `CWPD_EE_BASE, 14'h0000, 2'h1);
		rchk(`CWPD_OFF_EXT_RDATA, 32'h0000_0ABC);
		cmd(1'b1, 16'h0005, 14'h0000, 2'h1);
		st(3, 3'h1);
		boot(14'h3EFF, 14'h3FFF, 1'b1, 1'b0);
		cmd(1'b0, `CWPD_EE_BASE, 14'h0000, 2'h1);
		st(0, 3'h2);
		cmd(1'b1, `CWPD_EE_BASE, 14'h0000, 2'h1);
		st(3, 3'h1);
		cmd(1'b0, 16'h0005, 14'h0000, 2'h1);
		rchk(`CWPD_OFF_EXT_RDATA, 32'h0000_1234);
	endtask
	task automatic t_wrt;
		logic [15:0] lim [0:2] = '{16'h07FF, 16'h03FF, 16'h01FF};
		for (int w = 0; w < 3; w++) begin
			boot(14'h3F7F, {12'hFFF, w[1:0]}, 1'b0, 1'b0);
			cmd(1'b1, lim[w], 14'h0011, 2'h2);
			st(3, 3'h2);
			cmd(1'b1, lim[w] + 16'h0001, 14'h0011, 2'h2);
			st(3, 3'h1);
		end
		boot(14'h3F7F, 14'h3FFF, 1'b0, 1'b0);
		cmd(1'b1, 16'h0000, 14'h0011, 2'h2);
		st(3, 3'h1);
	endtask
	task automatic t_lvp;
		boot(14'h3FFF, 14'h3FFF, 1'b0, 1'b1);
		`CHK(prog_session_active, 1'b1)
		cmd(1'b0, `CWPD_CFG2_ADDR, 14'h1FFF, 2'h2);
		st(0, 3'h2);
		cmd(1'b0, `CWPD_CFG2_ADDR, 14'h3FFF, 2'h2);
		st(0, 3'h1);
		boot(14'h3FFF, 14'h1FFF, 1'b0, 1'b1);
		`CHK(prog_session_active, 1'b0)
		cmd(1'b0, `CWPD_EE_BASE, 14'h0000, 2'h1);
		st(0, 3'h2);
	endtask
	initial begin
		#400000;
		err_count++;
		results();
	end
	initial begin
		t_decode();
		t_ident();
		t_guard();
		t_wrt();
		t_lvp();
		results();
	end
endmodule
`default_nettype wire
